//--- hw/spe_entry.sv
// serial programming entry and shift engine
// assumes programmer pins arrive asynchronously; memory interface is on core_clk
// Operation
// R1: data pin is two-way; clock pin is input only, driven by programmer.
// R2: in programming mode, program memory, ids and config words are written serially.
// R3: high-voltage entry needs clock and data low before voltage reaches entry level.
// R4: low-voltage entry allowed only while entry enable config bit is one.
// R5: with entry enable zero, key attempts are ignored; only high-voltage entry works.
// R6: low-voltage key: master clear low, then 32 bits sampled per clock pulse.
// R7: low-voltage mode lasts only while master clear stays low.
// R8: entry enable may be cleared to zero only in a high-voltage session.
// R9: key must match internal key fully; otherwise remain in normal operation.
`include "spe_defines.svh"
module spe_entry #(
    parameter int KEY_BITS  = `SPE_KEY_BITS,
    parameter int DATA_BITS = `SPE_DATA_BITS
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 prog_serial_clock,
    input  wire logic                 prog_serial_data_in,
    output logic                      prog_serial_data_out,
    output logic                      prog_serial_data_oe_n,
    input  wire logic                 master_clear_n,
    input  wire logic                 high_entry_voltage_level,
    input  wire logic                 low_voltage_entry_enable,
    output logic                      clear_entry_enable,
    output logic                      prog_mode,
    output logic                      high_voltage_session,
    output logic                      mem_write,
    output logic                      mem_config_sel,
    output logic [DATA_BITS-1:0]      mem_wdata,
    output logic [DATA_BITS-1:0]      mem_addr,
    input  wire logic [DATA_BITS-1:0] mem_rdata
);
    import spe_pkg::*;

    localparam int CW = `SPE_CMD_BITS;
    localparam int FRAME = DATA_BITS + 2;

    logic sClk;
    logic sDat;
    logic sMclrN;
    logic sHv;

    spe_sync u_sync_clk (.core_clk(core_clk), .reset(reset), .asyncIn(prog_serial_clock), .level(sClk));   // [R1]
    spe_sync u_sync_dat (.core_clk(core_clk), .reset(reset), .asyncIn(prog_serial_data_in), .level(sDat));
    spe_sync u_sync_mcl (.core_clk(core_clk), .reset(reset), .asyncIn(master_clear_n), .level(sMclrN));
    spe_sync u_sync_hv  (.core_clk(core_clk), .reset(reset), .asyncIn(high_entry_voltage_level), .level(sHv));

    spe_mode_t            mode;
    spe_mode_t            next_mode;
    logic                 clkPrev;
    logic                 hvPrev;
    logic [KEY_BITS-1:0]  keyShift;
    logic [KEY_BITS-1:0]  next_keyShift;
    logic [5:0]           keyCount;
    logic [5:0]           next_keyCount;
    logic                 inData;
    logic                 next_inData;
    logic [CW-1:0]        cmd;
    logic [CW-1:0]        next_cmd;
    logic [FRAME-1:0]     shiftReg;
    logic [FRAME-1:0]     next_shiftReg;
    logic [5:0]           bitCount;
    logic [5:0]           next_bitCount;
    logic                 reading;
    logic                 next_reading;
    logic [DATA_BITS-1:0] next_memAddr;
    logic [DATA_BITS-1:0] next_memWdata;
    logic                 next_memWrite;
    logic                 next_cfgSel;
    logic                 next_clearEn;
    logic                 next_dOut;
    logic                 next_oeN;
    logic                 rise;
    logic                 fall;
    logic                 inProg;

    assign rise   = sClk & ~clkPrev;
    assign fall   = ~sClk & clkPrev;
    assign inProg = (mode == SPE_LV) || (mode == SPE_HV);

    // entry, key and session control
    always_comb begin
        next_mode     = mode;
        next_keyShift = keyShift;
        next_keyCount = keyCount;
        case (mode)
            SPE_IDLE: begin
                next_keyCount = 6'h00;
                if (sHv && !hvPrev && !sClk && !sDat) begin
                    next_mode = SPE_HV;                                   // [R3]
                end else if (!sMclrN && low_voltage_entry_enable) begin  // [R4] [R5]
                    next_mode = SPE_KEY;                                  // [R6]
                end
            end
            SPE_KEY: begin
                if (sMclrN || !low_voltage_entry_enable) begin
                    next_mode = SPE_IDLE;                                 // [R5]
                end else if (sHv) begin
                    next_mode = SPE_IDLE;
                end else if (fall) begin
                    next_keyShift = {keyShift[KEY_BITS-2:0], sDat};       // [R6]
                    next_keyCount = keyCount + 6'h01;
                end else if (keyCount == 6'(KEY_BITS)) begin
                    next_keyCount = 6'h00;
                    if (keyShift == `SPE_KEY_VALUE) begin
                        next_mode = SPE_LV;                               // [R9]
                    end
                end
            end
            SPE_LV: begin
                if (sMclrN) begin
                    next_mode = SPE_IDLE;                                 // [R7]
                end
            end
            SPE_HV: begin
                if (!sHv) begin
                    next_mode = SPE_IDLE;
                end
            end
            default: next_mode = SPE_IDLE;
        endcase
    end

    // command and data shifting, lsb first; reads drive data out
    always_comb begin
        next_inData   = inData;
        next_cmd      = cmd;
        next_shiftReg = shiftReg;
        next_bitCount = bitCount;
        next_reading  = reading;
        next_memAddr  = mem_addr;
        next_memWdata = mem_wdata;
        next_memWrite = 1'b0;
        next_cfgSel   = mem_config_sel;
        next_clearEn  = 1'b0;
        next_dOut     = prog_serial_data_out;
        next_oeN      = prog_serial_data_oe_n;
        if (!inProg) begin
            next_inData   = 1'b0;
            next_bitCount = 6'h00;
            next_reading  = 1'b0;
            next_oeN      = 1'b1;
            next_dOut     = 1'b0;
            next_cfgSel   = 1'b0;
            next_memAddr  = '0;
        end else if (fall) begin
            next_bitCount = bitCount + 6'h01;
            if (!inData) begin
                next_cmd = {sDat, cmd[CW-1:1]};
                if (bitCount == 6'(CW - 1)) begin
                    next_bitCount = 6'h00;
                    case ({sDat, cmd[CW-1:1]})
                        `SPE_CMD_LOAD_CFG: begin
                            next_inData = 1'b1;
                            next_cfgSel = 1'b1;                           // [R2]
                            next_memAddr = '0;
                        end
                        `SPE_CMD_LOAD_PROG: next_inData = 1'b1;
                        `SPE_CMD_READ_PROG: begin
                            next_inData   = 1'b1;
                            next_reading  = 1'b1;
                            next_shiftReg = {1'b0, mem_rdata, 1'b0};
                        end
                        `SPE_CMD_INC_ADDR: next_memAddr = mem_addr + 1'b1;
                        `SPE_CMD_BEGIN_PROG: next_memWrite = 1'b1;        // [R2]
                        `SPE_CMD_CLR_LVE: next_clearEn = (mode == SPE_HV); // [R8]
                        default: next_inData = 1'b0;
                    endcase
                end
            end else begin
                // read frames shift only on rising edges, else bits are skipped
                if (!reading) begin
                    next_shiftReg = {sDat, shiftReg[FRAME-1:1]};
                end
                if (bitCount == 6'(FRAME - 1)) begin
                    next_bitCount = 6'h00;
                    next_inData   = 1'b0;
                    next_reading  = 1'b0;
                    next_oeN      = 1'b1;
                    if (!reading) begin
                        next_memWdata = next_shiftReg[DATA_BITS:1];       // [R2]
                    end
                end
            end
        end else if (rise && inData && reading) begin
            next_oeN  = 1'b0;                                             // [R1]
            next_dOut = shiftReg[0];
            next_shiftReg = {1'b0, shiftReg[FRAME-1:1]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode                  <= SPE_IDLE;
            clkPrev               <= 1'b0;
            hvPrev                <= 1'b0;
            keyShift              <= '0;
            keyCount              <= 6'h00;
            inData                <= 1'b0;
            cmd                   <= '0;
            shiftReg              <= '0;
            bitCount              <= 6'h00;
            reading               <= 1'b0;
            mem_addr              <= '0;
            mem_wdata             <= '0;
            mem_write             <= 1'b0;
            mem_config_sel        <= 1'b0;
            clear_entry_enable    <= 1'b0;
            prog_serial_data_out  <= 1'b0;
            prog_serial_data_oe_n <= 1'b1;
        end else begin
            mode                  <= next_mode;
            clkPrev               <= sClk;
            hvPrev                <= sHv;
            keyShift              <= next_keyShift;
            keyCount              <= next_keyCount;
            inData                <= next_inData;
            cmd                   <= next_cmd;
            shiftReg              <= next_shiftReg;
            bitCount              <= next_bitCount;
            reading               <= next_reading;
            mem_addr              <= next_memAddr;
            mem_wdata             <= next_memWdata;
            mem_write             <= next_memWrite;
            mem_config_sel        <= next_cfgSel;
            clear_entry_enable    <= next_clearEn;
            prog_serial_data_out  <= next_dOut;
            prog_serial_data_oe_n <= next_oeN;
        end
    end

    assign prog_mode            = inProg;
    assign high_voltage_session = (mode == SPE_HV);
endmodule // spe_entry

//--- hw/spe_defines.svh
// constants for the serial programming entry block
// assumes inclusion by bare name from hw/
`ifndef SPE_DEFINES_SVH
`define SPE_DEFINES_SVH
`define SPE_KEY_BITS        32
`define SPE_KEY_VALUE       32'h5a3c_96e1
`define SPE_SYNC_STAGES     3
`define SPE_CMD_BITS        6
`define SPE_DATA_BITS       16
`define SPE_CMD_LOAD_CFG    6'h00
`define SPE_CMD_LOAD_PROG   6'h02
`define SPE_CMD_READ_PROG   6'h04
`define SPE_CMD_INC_ADDR    6'h06
`define SPE_CMD_BEGIN_PROG  6'h08
`define SPE_CMD_CLR_LVE     6'h0a
`endif

//--- hw/spe_pkg.sv
// types for the serial programming entry block
// assumes spe_defines.svh on the include path
package spe_pkg;
    typedef enum logic [1:0] {
        SPE_IDLE = 2'b00,
        SPE_KEY  = 2'b01,
        SPE_LV   = 2'b11,
        SPE_HV   = 2'b10
    } spe_mode_t;
endpackage

//--- hw/spe_sync.sv
// three-stage synchroniser with agreement filter on the last two stages
// assumes an asynchronous input and the core clock
module spe_sync (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb begin
        next_stage = {stage[1:0], asyncIn};
        next_level = (stage[2] == stage[1]) ? stage[1] : level;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule // spe_sync

//--- verification/spe_entry_asserts.sv
// assertions on the serial programming entry ports
// assumes binding into spe_entry, one core_clk domain
module spe_entry_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic prog_serial_clock,
    input wire logic master_clear_n,
    input wire logic high_entry_voltage_level,
    input wire logic low_voltage_entry_enable,
    input wire logic prog_serial_data_oe_n,
    input wire logic clear_entry_enable,
    input wire logic prog_mode,
    input wire logic high_voltage_session,
    input wire logic mem_write
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_drive_on_rise: assert property ($fell(prog_serial_data_oe_n) |-> prog_serial_clock && prog_mode)
        else $error("data pin driven off a rising clock");
    chk_write_in_mode: assert property (mem_write |-> prog_mode)
        else $error("memory write outside programming mode");
    chk_hv_entry: assert property ($rose(high_voltage_session) |-> prog_mode && high_entry_voltage_level)
        else $error("high voltage session without entry level");
    chk_hv_refuse: assert property ($rose(high_entry_voltage_level) && prog_serial_clock && !prog_mode
        |=> !high_voltage_session [*8])
        else $error("high voltage entry with clock high");
    chk_lv_gate: assert property ($rose(prog_mode) && !high_voltage_session |-> low_voltage_entry_enable)
        else $error("key entry while disabled");
    chk_lv_blocked: assert property (!low_voltage_entry_enable && !prog_mode
        |=> !prog_mode || high_voltage_session)
        else $error("key entry taken while disabled");
    chk_lv_master_clear_n_low: assert property ($rose(prog_mode) && !high_voltage_session |-> !master_clear_n)
        else $error("key entry with master clear high");
    chk_lv_exit: assert property (prog_mode && !high_voltage_session && master_clear_n
        |-> ##[1:8] !prog_mode)
        else $error("key mode kept after master clear release");
    chk_clr_hv_only: assert property (clear_entry_enable |-> high_voltage_session && prog_mode)
        else $error("entry enable cleared outside high voltage");
    cover property ($rose(high_voltage_session));
    cover property ($rose(prog_mode) && !high_voltage_session);
    cover property ($fell(prog_serial_data_oe_n));
endmodule // spe_entry_asserts
bind spe_entry spe_entry_asserts chk_u (.core_clk, .reset, .prog_serial_clock, .master_clear_n,
    .high_entry_voltage_level, .low_voltage_entry_enable, .prog_serial_data_oe_n, .clear_entry_enable,
    .prog_mode, .high_voltage_session, .mem_write);

//--- verification/spe_programmer.sv
// programmer model: serial clock, data, master clear, entry level
// assumes bench calls the tasks; clock rests low between frames
module spe_programmer (
    output logic      serClk,
    output logic      mclrN,
    output logic      hvLevel,
    output logic      dataToDev,
    input  wire logic devOut,
    input  wire logic devOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        drv = 1'b0;
    logic        val = 1'b0;
    logic [17:0] got;
    // released line shows the inverse of the last bit
    assign dataToDev = !devOeN ? devOut : (drv ? val : !val);
    initial begin
        serClk = 1'b0;
        mclrN = 1'b1;
        hvLevel = 1'b0;
    end
    task automatic hvSet(input logic lvl, input logic clkLvl);
        serClk = clkLvl;
        drv = 1'b1;
        val = 1'b0;
        #200 hvLevel = lvl;
        #200 serClk = 1'b0;
    endtask
    task automatic setMclr(input logic v);
        mclrN = v;
        #200;
    endtask
    task automatic shift(input logic [31:0] v, input int n, input logic msb, input logic rd);
        for (int i = 0; i < n; i++) begin
            drv = !rd;
            val = msb ? v[n-1-i] : v[i];
            #10 serClk = 1'b1;
            #62.5 serClk = 1'b0;
            got = {dataToDev, got[17:1]};
            #52.5;
        end
        drv = 1'b0;
        #200;
    endtask
endmodule // spe_programmer

//--- verification/serial_programming_entry_bench.sv
// self-checking bench for the serial programming entry block
// assumes spe_programmer on the far side and the bound checker
`include "spe_defines.svh"
module serial_programming_entry_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        lvEnable = 1'b1;
    logic [15:0] rdWord = 16'h3c5a;
    logic        serClk, mclrN, hvLevel, dataIn, dataOut, oeN, clrPulse, progMode, hvSession, memWrite, cfgSel;
    logic [15:0] wData, lastWd, addr;
    int          nFail = 0;
    int          testsRun = 0;
    int          nWr = 0;
    int          nClr = 0;
    int          base;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    spe_programmer prog_u (.serClk(serClk), .mclrN(mclrN), .hvLevel(hvLevel), .dataToDev(dataIn),
        .devOut(dataOut), .devOeN(oeN));
    spe_entry dut_u (.core_clk(core_clk), .reset(reset), .prog_serial_clock(serClk),
        .prog_serial_data_in(dataIn), .prog_serial_data_out(dataOut), .prog_serial_data_oe_n(oeN),
        .master_clear_n(mclrN), .high_entry_voltage_level(hvLevel), .low_voltage_entry_enable(lvEnable),
        .clear_entry_enable(clrPulse), .prog_mode(progMode), .high_voltage_session(hvSession),
        .mem_write(memWrite), .mem_config_sel(cfgSel), .mem_wdata(wData), .mem_addr(addr), .mem_rdata(rdWord));
    // pulses are counted mid-cycle, where they are settled
    always @(negedge core_clk) begin
        if (memWrite === 1'b1) begin
            nWr++;
            lastWd = wData;
        end
        if (clrPulse === 1'b1) nClr++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic sHvRefuse();
        prog_u.hvSet(1'b1, 1'b1);
        check(hvSession, 1'b0);
        prog_u.hvSet(1'b0, 1'b0);
    endtask
    task automatic sHvSession();
        prog_u.hvSet(1'b1, 1'b0);
        check(hvSession, 1'b1);
        base = nWr;
        prog_u.shift(`SPE_CMD_LOAD_PROG, 6, 1'b0, 1'b0);
        prog_u.shift({14'h0, 1'b0, 16'ha5c3, 1'b0}, 18, 1'b0, 1'b0);
        prog_u.shift(`SPE_CMD_BEGIN_PROG, 6, 1'b0, 1'b0);
        check(nWr - base, 1);
        check(lastWd, 16'ha5c3);
        prog_u.shift(`SPE_CMD_INC_ADDR, 6, 1'b0, 1'b0);
        check(addr, 16'h0001);
        prog_u.shift(`SPE_CMD_LOAD_CFG, 6, 1'b0, 1'b0);
        prog_u.shift({14'h0, 1'b0, 16'h0f1e, 1'b0}, 18, 1'b0, 1'b0);
        check(cfgSel, 1'b1);
        check(addr, 16'h0000);
        check(wData, 16'h0f1e);
        base = nClr;
        prog_u.shift(`SPE_CMD_CLR_LVE, 6, 1'b0, 1'b0);
        check(nClr - base, 1);
        prog_u.hvSet(1'b0, 1'b0);
        check(progMode, 1'b0);
        check(cfgSel, 1'b0);
    endtask
    task automatic sLvOff();
        @(negedge core_clk);
        lvEnable = 1'b0;
        prog_u.setMclr(1'b0);
        prog_u.shift(`SPE_KEY_VALUE, 32, 1'b1, 1'b0);
        check(progMode, 1'b0);
        prog_u.setMclr(1'b1);
        @(negedge core_clk);
        lvEnable = 1'b1;
    endtask
    task automatic sLv();
        prog_u.setMclr(1'b0);
        prog_u.shift(`SPE_KEY_VALUE ^ 32'h1, 32, 1'b1, 1'b0);
        check(progMode, 1'b0);
        prog_u.shift(`SPE_KEY_VALUE, 32, 1'b1, 1'b0);
        check(progMode, 1'b1);
        base = nClr;
        prog_u.shift(`SPE_CMD_CLR_LVE, 6, 1'b0, 1'b0);
        check(nClr - base, 0);
        prog_u.shift(`SPE_CMD_READ_PROG, 6, 1'b0, 1'b0);
        prog_u.shift(32'h0, 18, 1'b0, 1'b1);
        check(prog_u.got[16:1], rdWord);
        check(oeN, 1'b1);
        prog_u.setMclr(1'b1);
        check(progMode, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        repeat (5) @(negedge core_clk);
        sHvRefuse();
        sHvSession();
        sLvOff();
        sLv();
        end_sim();
    end
    initial begin
        #200us;
        nFail++;
        end_sim();
    end
endmodule // serial_programming_entry_bench
